// >>> src/iwqu_regs.svh
// iwqu_regs.svh: constants of the integer word quotient unit
// assumes inclusion by the unit's design file and the testbench
`ifndef IWQU_REGS_SVH
`define IWQU_REGS_SVH
`define IWQU_OP_PRIMARY   6'h00
`define IWQU_FN_SIGNED    6'h1A
`define IWQU_FN_UNSIGNED  6'h1B
`define IWQU_ZERO_FIELD   10'h000
`define IWQU_STEPS        6'h20
`endif

// >>> src/iwqu_pkg.sv
// iwqu_pkg.sv: types of the integer word quotient unit
// assumes the constants header sits beside it
package iwqu_pkg;
    typedef enum logic [1:0] {IWQU_IDLE, IWQU_RUN, IWQU_FIX} iwqu_state_e;
    // one issued operation from the pipeline
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] numer;
        logic [63:0] denom;
    } iwqu_issue_s;
    // the two result holders
    typedef struct packed {
        logic [63:0] quot;
        logic [63:0] rem;
    } iwqu_result_s;
endpackage

// >>> src/iwqu_unit.sv
// iwqu_unit.sv: 32-bit word divide datapath with result holders and interlock
// assumes the pipeline presents issues and reads synchronously to sys_clk
`timescale 1ns/1ps
`include "iwqu_regs.svh"
module iwqu_unit
    import iwqu_pkg::*;
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    // issue from pipeline
    input  wire iwqu_issue_s  issue,
    output logic              issue_ready,
    // holder reads
    input  wire logic         move_from_quotient,
    input  wire logic         move_from_remainder,
    output logic              read_stall,
    output logic [63:0]       read_data,
    // holders and status
    output iwqu_result_s      holders,
    output logic              busy,
    output logic              trap
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic is_div(input logic [31:0] ins, input logic [5:0] fn);
        is_div = (ins[31:26] == `IWQU_OP_PRIMARY) && (ins[15:6] == `IWQU_ZERO_FIELD) && (ins[5:0] == fn);
    endfunction

    // two's complement negate on request; shared by operand magnitudes and result signs
    function automatic logic [31:0] negw(input logic [31:0] v, input logic n);
        negw = n ? (32'h0 - v) : v;
    endfunction

    // magnitude of a signed word, unsigned words pass untouched
    function automatic logic [31:0] absw(input logic [31:0] v, input logic s);
        absw = negw(v, s && v[31]);
    endfunction

    logic        dec_signed;
    logic        dec_unsigned;
    logic        start;
    assign dec_signed   = is_div(issue.instr, `IWQU_FN_SIGNED);
    assign dec_unsigned = is_div(issue.instr, `IWQU_FN_UNSIGNED);

    iwqu_state_e state;
    logic [5:0]  count;
    logic [31:0] dvd;
    logic [31:0] dvs;
    logic [32:0] part;
    logic        neg_q;
    logic        neg_r;
    logic [32:0] trial;

    // ----------------------------------------------------------------
    // control
    // ----------------------------------------------------------------
    // a new divide is taken whenever idle, right after reads
    assign issue_ready = (state == IWQU_IDLE);
    assign start       = issue.valid && issue_ready && (dec_signed || dec_unsigned);
    assign busy        = (state != IWQU_IDLE);
    // no exception path at all, zero divisor included
    assign trap        = 1'b0;

    // reads stall while the holders are stale
    assign read_stall  = busy && (move_from_quotient || move_from_remainder);
    assign read_data   = move_from_quotient ? holders.quot : holders.rem;

    // the unit blocks holder reads and, with issue_ready low, every new issue while busy
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= IWQU_IDLE;
            count <= 6'h00;
        end else begin
            unique case (state)
                IWQU_IDLE: begin
                    if (start) begin
                        state <= IWQU_RUN;
                        count <= `IWQU_STEPS;
                    end
                end
                IWQU_RUN: begin
                    count <= count - 6'h01;
                    if (count == 6'h01) begin
                        state <= IWQU_FIX;
                    end
                end
                IWQU_FIX: begin
                    state <= IWQU_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // restoring divider, one quotient bit per cycle
    // ----------------------------------------------------------------
    assign trial = {part[31:0], dvd[31]} - {1'b0, dvs};

    // zero divisor simply runs out, giving all-ones quotient, or 1 for a signed negative dividend
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dvd   <= 32'h0;
            dvs   <= 32'h0;
            part  <= 33'h0;
            neg_q <= 1'b0;
            neg_r <= 1'b0;
        end else if (start) begin
            // signed uses magnitudes of low words
            // unsigned takes low words as they are
            dvd   <= absw(issue.numer[31:0], dec_signed);
            dvs   <= absw(issue.denom[31:0], dec_signed);
            part  <= 33'h0;
            // quotient sign from both, remainder from dividend
            neg_q <= dec_signed && (issue.numer[31] ^ issue.denom[31]);
            neg_r <= dec_signed && issue.numer[31];
        end else if (state == IWQU_RUN) begin
            if (!trial[32]) begin
                part <= trial;
                dvd  <= {dvd[30:0], 1'b1};
            end else begin
                part <= {part[31:0], dvd[31]};
                dvd  <= {dvd[30:0], 1'b0};
            end
        end
    end

    // ----------------------------------------------------------------
    // result holders
    // ----------------------------------------------------------------
    logic [31:0] q_fin;
    logic [31:0] r_fin;
    assign q_fin = negw(dvd, neg_q);
    assign r_fin = negw(part[31:0], neg_r);

    // holders change only at completion, so overlap is invisible
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            holders <= '0;
        end else if (state == IWQU_FIX) begin
            holders.quot <= {{32{q_fin[31]}}, q_fin};
            holders.rem  <= {{32{r_fin[31]}}, r_fin};
        end
    end

    // ----------------------------------------------------------------
    // completion marker
    // ----------------------------------------------------------------
    logic        hold_wr;

    // high in the cycle after a write, so checks need no past value of an expression
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold_wr <= 1'b0;
        end else begin
            hold_wr <= (state == IWQU_FIX);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // latency: take edge, 32 steps, one fix cycle; busy is low at the 34th sample after start
    a_done_in_time: assert property (@(posedge sys_clk) disable iff (!nrst)
        start |-> ##34 !busy)
        else $error("divide did not finish in 34 cycles");
    a_zero_done: assert property (@(posedge sys_clk) disable iff (!nrst)
        (start && (issue.denom[31:0] == 32'h0)) |-> ##34 (!busy && !trap))
        else $error("zero divisor divide did not finish");
    a_fix_single: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == IWQU_FIX) |=> (state == IWQU_IDLE))
        else $error("fix phase lasted more than one cycle");

    // stall and trap
    a_read_stalls: assert property (@(posedge sys_clk) disable iff (!nrst)
        (busy && (move_from_quotient || move_from_remainder)) |-> read_stall)
        else $error("early read not stalled");
    a_idle_no_stall: assert property (@(posedge sys_clk) disable iff (!nrst)
        !busy |-> !read_stall)
        else $error("read stalled while idle");
    a_never_traps: assert property (@(posedge sys_clk) disable iff (!nrst)
        !trap)
        else $error("arithmetic trap raised");

    // holder contents
    a_holder_steady: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == IWQU_RUN) |=> $stable(holders))
        else $error("holders changed mid divide");
    a_idle_holders: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == IWQU_IDLE) |=> $stable(holders))
        else $error("holders changed while idle");
    a_sign_ext: assert property (@(posedge sys_clk) disable iff (!nrst)
        hold_wr |-> (holders.quot[63:32] == {32{holders.quot[31]}})
                    && (holders.rem[63:32] == {32{holders.rem[31]}}))
        else $error("result not sign-extended");
    a_rem_sign: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hold_wr && neg_r && (holders.rem[31:0] != 32'h0)) |-> holders.rem[31])
        else $error("remainder sign differs from dividend");
    a_quot_sign: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hold_wr && neg_q && (dvs != 32'h0) && (holders.quot[31:0] != 32'h0)) |-> holders.quot[31])
        else $error("quotient sign wrong for mixed signs");

    // decode and start
    a_decode_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        (issue.valid && !busy && !dec_signed && !dec_unsigned) |=> !busy)
        else $error("foreign instruction started a divide");
    a_signed_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        (issue.valid && issue_ready && dec_signed) |=> (state == IWQU_RUN) && (count == `IWQU_STEPS))
        else $error("signed divide not started");
    a_unsigned_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        (issue.valid && issue_ready && dec_unsigned) |=> (state == IWQU_RUN) && (count == `IWQU_STEPS))
        else $error("unsigned divide not started");
endmodule // iwqu_unit

// >>> tb/iwqu_pipe_model.sv
// iwqu_pipe_model.sv: pipeline side that issues word divides to the unit
// assumes one caller at a time, called just after a rising edge
`timescale 1ns/1ps
module iwqu_pipe_model
    import iwqu_pkg::*;
(
    // clock
    input  wire logic   sys_clk,
    // issue handshake
    input  wire logic   issue_ready,
    output iwqu_issue_s issue
);
    initial issue = '0;
    // hold the request until an edge that sees ready, then scramble the stale operands
    task automatic send(input logic [5:0] fn, input logic [31:0] a, input logic [31:0] b);
        // start on a fresh edge so a back-to-back call never meets the previous release
        @(posedge sys_clk);
        issue <= '{1'b1, {6'h00, 5'h04, 5'h05, 10'h000, fn}, {{32{a[31]}}, a}, {{32{b[31]}}, b}};
        do @(negedge sys_clk); while (issue_ready !== 1'b1);
        @(posedge sys_clk);
        issue <= '{1'b0, ~issue.instr, ~issue.numer, ~issue.denom};
    endtask
endmodule // iwqu_pipe_model

// >>> tb/testbench.sv
// testbench.sv: self-checking bench for the word divide unit
// assumes the pipeline model beside it and the design under src
`timescale 1ns/1ps
`include "iwqu_regs.svh"
module testbench;
    import iwqu_pkg::*;
    logic         sys_clk, nrst, move_from_quotient, move_from_remainder;
    logic         issue_ready, read_stall, busy, trap;
    logic [63:0]  read_data;
    iwqu_issue_s  issue;
    iwqu_result_s holders;
    logic [128:0] exp_q[$];
    logic [128:0] note;
    logic         last_busy = 1'b0;
    int           err_total = 0;
    int           compares = 0;
    logic [31:0]  na_tab[4] = '{32'h7, 32'hFFFFFFF9, 32'h80000000, 32'hFFFFFFFF};
    logic [31:0]  nb_tab[4] = '{32'h2, 32'h2, 32'hFFFFFFFF, 32'h3};
    iwqu_unit u_iwqu_unit (.sys_clk(sys_clk), .nrst(nrst), .issue(issue), .issue_ready(issue_ready),
        .move_from_quotient(move_from_quotient), .move_from_remainder(move_from_remainder),
        .read_stall(read_stall), .read_data(read_data), .holders(holders), .busy(busy), .trap(trap));
    iwqu_pipe_model u_iwqu_pipe_model (.sys_clk(sys_clk), .issue_ready(issue_ready), .issue(issue));
    // ----------------------------------------
    // clock, checks and expectations
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // top bit marks a zero divisor, whose holders are left unchecked
    function automatic logic [128:0] expect_div(input logic sgn, input logic [31:0] a, input logic [31:0] b);
        logic [63:0] x, y, q, r;
        x = sgn ? {{32{a[31]}}, a} : {32'h0, a};
        y = sgn ? {{32{b[31]}}, b} : {32'h0, b};
        q = sgn ? 64'($signed(x) / $signed(y)) : x / y;
        r = sgn ? 64'($signed(x) % $signed(y)) : x % y;
        return {b == 32'h0, {{32{q[31]}}, q[31:0]}, {{32{r[31]}}, r[31:0]}};
    endfunction
    task automatic div(input logic sgn, input logic [31:0] a, input logic [31:0] b);
        exp_q.push_back(expect_div(sgn, a, b));
        u_iwqu_pipe_model.send(sgn ? `IWQU_FN_SIGNED : `IWQU_FN_UNSIGNED, a, b);
    endtask
    task automatic wait_idle();
        int n = 0;
        @(negedge sys_clk);
        while (busy !== 1'b0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check(n < 40, "unit stuck busy");
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // result watcher: each fall of busy consumes the oldest note
    always @(negedge sys_clk) begin
        last_busy <= busy;
        if (last_busy === 1'b1 && busy === 1'b0) begin
            check(exp_q.size() != 0, "result without issue");
            note = exp_q.pop_front();
            check(note[128] | (holders === note[127:0]), "holders differ");
            check(trap === 1'b0, "trap raised");
        end
    end
    // hang guard, far beyond the roughly 1100 cycles needed
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {nrst, move_from_quotient, move_from_remainder} = 3'h0;
        void'($urandom(35));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        check(holders === '0 && issue_ready === 1'b1, "reset state");
        @(posedge sys_clk);
        for (int k = 0; k < 8; k++) div(k[0], na_tab[k >> 1], nb_tab[k >> 1]);
        div(1'b1, 32'h5, 32'h0);
        div(1'b0, 32'h5, 32'h0);
        wait_idle();
        $display("corner divides done");
        @(posedge sys_clk);
        u_iwqu_pipe_model.send(6'h18, 32'h5, 32'h1);
        repeat (3) @(negedge sys_clk);
        check(busy === 1'b0, "other function started");
        $display("decode test done");
        @(posedge sys_clk);
        div(1'b1, 32'd100, 32'd7);
        @(negedge sys_clk);
        check(read_stall === 1'b0, "stall without read");
        @(posedge sys_clk);
        move_from_quotient <= 1'b1;
        @(negedge sys_clk);
        check(read_stall === 1'b1, "early read not held");
        wait_idle();
        check(read_stall === 1'b0 && read_data === 64'hE, "quotient read");
        @(posedge sys_clk);
        {move_from_quotient, move_from_remainder} <= 2'h1;
        @(negedge sys_clk);
        check(read_data === 64'h2, "remainder read");
        @(posedge sys_clk);
        move_from_remainder <= 1'b0;
        div(1'b0, 32'hFFFFFFF0, 32'h3);
        for (int k = 0; k < 20; k++) div(1'($urandom), $urandom, $urandom);
        wait_idle();
        @(posedge sys_clk);
        check(exp_q.size() == 0, "results missing");
        $display("interlock and random done");
        complete_run();
    end
endmodule // testbench
